// ---- hw/sink_driver_pkg.sv ----
// shared constants and types for the serial shift-latch sink driver
package sink_driver_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int unsigned CHANNELS     = 12;
	localparam int unsigned FIFO_DEPTH   = 4;
	localparam int unsigned FIFO_WIDTH   = 1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [CHANNELS-1:0] CHANNELS_CLEAR = 12'h000;
	localparam logic                BIT_CLEAR      = 1'h0;
	localparam logic                BIT_SET        = 1'h1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned LINK_PERIOD_NS  = 12;
	// idle cycles with the fifo empty before a latch is taken
	localparam int unsigned SETTLE_CYCLES   = 2;
	localparam int unsigned SETTLE_W        = 2;
	localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 2'h0;
	localparam logic [SETTLE_W-1:0] SETTLE_ONE  = 2'h1;
	localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

	// ----------------------------------------------------------------
	// latch sequencer, gray coded along idle -> drain -> settle
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LATCH_IDLE   = 2'h0,
		LATCH_DRAIN  = 2'h1,
		LATCH_SETTLE = 2'h3
	} latch_state_t;

endpackage

// ---- hw/cross_fifo.sv ----
// dual-clock fifo with gray-coded pointers, valid/ready on both sides
`timescale 1ns/1ns
module cross_fifo
	import sink_driver_pkg::*;
#(
	parameter int unsigned WIDTH = FIFO_WIDTH,
	parameter int unsigned DEPTH = FIFO_DEPTH
)
(
	input  wire logic             wr_clk,
	input  wire logic             wr_rst_n,
	input  wire logic             wr_valid,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  wr_ready,
	input  wire logic             rd_clk,
	input  wire logic             rd_rst_n,
	input  wire logic             rd_ce,
	output logic                  rd_valid,
	output logic      [WIDTH-1:0] rd_data,
	input  wire logic             rd_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned PW = AW + 1;
	localparam logic [PW-1:0] PTR_ZERO = '0;
	localparam logic [PW-1:0] PTR_ONE  = PW'(1);

	function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
		to_gray = b ^ (b >> 1);
	endfunction

	typedef struct packed {
		logic [PW-1:0] bin;
		logic [PW-1:0] gray;
		logic [PW-1:0] sync1;
		logic [PW-1:0] sync2;
	} side_t;

	side_t            wr;
	side_t            next_wr;
	side_t            rd;
	side_t            next_rd;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	// ----------------------------------------------------------------
	// write side
	// ----------------------------------------------------------------
	// full when the pointers differ only in their top two gray bits
	assign wr_ready = (wr.gray != {~wr.sync2[PW-1 -: 2], wr.sync2[PW-3:0]});
	assign push     = wr_valid && wr_ready;

	always_comb
	begin
		next_wr       = wr;
		next_wr.sync1 = rd.gray;
		next_wr.sync2 = wr.sync1;
		if (push)
		begin
			next_wr.bin  = wr.bin + PTR_ONE;
			next_wr.gray = to_gray(wr.bin + PTR_ONE);
		end
	end

	always_ff @(posedge wr_clk or negedge wr_rst_n)
	begin
		if (!wr_rst_n)
			wr <= '{PTR_ZERO, PTR_ZERO, PTR_ZERO, PTR_ZERO};
		else
			wr <= next_wr;
	end

	// storage is not reset; only words behind the write pointer are read
	always_ff @(posedge wr_clk)
	begin
		if (push)
			mem[wr.bin[AW-1:0]] <= wr_data;
	end

	// ----------------------------------------------------------------
	// read side
	// ----------------------------------------------------------------
	assign rd_valid = (rd.gray != rd.sync2);
	assign rd_data  = mem[rd.bin[AW-1:0]];
	assign pop      = rd_valid && rd_ready && rd_ce;

	always_comb
	begin
		next_rd = rd;
		if (rd_ce)
		begin
			next_rd.sync1 = wr.gray;
			next_rd.sync2 = rd.sync1;
		end
		if (pop)
		begin
			next_rd.bin  = rd.bin + PTR_ONE;
			next_rd.gray = to_gray(rd.bin + PTR_ONE);
		end
	end

	always_ff @(posedge rd_clk or negedge rd_rst_n)
	begin
		if (!rd_rst_n)
			rd <= '{PTR_ZERO, PTR_ZERO, PTR_ZERO, PTR_ZERO};
		else
			rd <= next_rd;
	end

endmodule

// ---- hw/sink_driver.sv ----
// serial-in shift register, storage latch and gated sink channel driver
`timescale 1ns/1ns

// Functional notes
// - twelve-stage shift register, one step per shift edge
// - latch edge copies all stages into storage
// - shift and latch clocks act independently
// - clear low zeroes the shift, storage and buffer registers; it sets the enable synchronisers
// - storage reaches buffer only while clear high
// - enable high forces all buffer bits low
// - enable low: buffer follows storage, registered on the system clock
// - buffer bit one sinks, zero is off
// - cascade output changes on falling shift edge
module sink_driver
	import sink_driver_pkg::*;
#(
	parameter int unsigned WIDTH = CHANNELS,
	parameter int unsigned DEPTH = FIFO_DEPTH
)
(
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             en,
	input  wire logic             shift_clk,
	input  wire logic             serial_in,
	input  wire logic             latch_clk,
	input  wire logic             clear_all_n,
	input  wire logic             output_enable_n,
	output logic                  shift_ready,
	output logic                  bit_lost,
	output logic                  cascade_serial_out,
	output logic      [WIDTH-1:0] sink_channel_out,
	output logic      [WIDTH-1:0] sink_channel_oe_n,
	output logic      [WIDTH-1:0] sink_channel_on,
	output logic                  latch_busy,
	output logic      [WIDTH-1:0] storage_view
);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// shift-clock domain, rising edge
	typedef struct packed {
		logic [WIDTH-1:0] stages;
		logic             lost;
	} link_t;

	// shift-clock domain, falling edge
	typedef struct packed {
		logic cascade;
	} tail_t;

	// system clock domain
	typedef struct packed {
		logic               latch_q1;
		logic               latch_q2;
		logic               latch_q3;
		logic               oe_n_q1;
		logic               oe_n_q2;
		logic [WIDTH-1:0]   mirror;
		logic [WIDTH-1:0]   storage;
		logic [WIDTH-1:0]   buffer;
		latch_state_t       state;
		logic [SETTLE_W-1:0] settle;
	} sys_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// one step of the serial-in chain; stage 0 takes the new bit
	function automatic logic [WIDTH-1:0] shift_in(
		input logic [WIDTH-1:0] cur,
		input logic             bit_in
	);
		shift_in = {cur[WIDTH-2:0], bit_in};
	endfunction

	// output gate: enable pin high blanks every channel
	function automatic logic [WIDTH-1:0] gate_out(
		input logic [WIDTH-1:0] data,
		input logic             oe_n
	);
		gate_out = oe_n ? CHANNELS_CLEAR : data;
	endfunction

	// ----------------------------------------------------------------
	// resets
	// ----------------------------------------------------------------
	// the clear pin acts at once, without either clock, on both domains
	logic clr_rst_n;

	assign clr_rst_n = arst_n & clear_all_n;

	// ----------------------------------------------------------------
	// link domain: the shift register itself
	// ----------------------------------------------------------------
	link_t link;
	link_t next_link;
	tail_t tail;
	tail_t next_tail;
	logic  fifo_wr_ready;

	always_comb
	begin
		next_link        = link;
		next_link.stages = shift_in(link.stages, serial_in);
		// a bit the fifo could not take never reaches the storage copy
		if (!fifo_wr_ready)
			next_link.lost = BIT_SET;
	end

	always_ff @(posedge shift_clk or negedge clr_rst_n)
	begin
		if (!clr_rst_n)
			link <= '{CHANNELS_CLEAR, BIT_CLEAR};
		else
			link <= next_link;
	end

	always_comb
	begin
		next_tail         = tail;
		next_tail.cascade = link.stages[WIDTH-1];
	end

	// half a link period of extra hold for the next device in a chain
	always_ff @(negedge shift_clk or negedge clr_rst_n)
	begin
		if (!clr_rst_n)
			tail <= '{cascade: BIT_CLEAR};
		else
			tail <= next_tail;
	end

	assign cascade_serial_out = tail.cascade;
	assign bit_lost           = link.lost;

	// ----------------------------------------------------------------
	// crossing: every shifted bit the fifo accepts passes it in order
	// ----------------------------------------------------------------
	logic sys_ce;
	logic fifo_rd_valid;
	logic fifo_rd_data;

	assign sys_ce = en;

	cross_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (DEPTH)
	) u_bit_fifo (
		.wr_clk   (shift_clk),
		.wr_rst_n (clr_rst_n),
		.wr_valid (BIT_SET),
		.wr_data  (serial_in),
		.wr_ready (fifo_wr_ready),
		.rd_clk   (clk),
		.rd_rst_n (clr_rst_n),
		.rd_ce    (sys_ce),
		.rd_valid (fifo_rd_valid),
		.rd_data  (fifo_rd_data),
		.rd_ready (BIT_SET)
	);

	// the host must hold off shift edges while this is low
	// limitation: only shift edges refresh it, so a stalled host must pace, not wait
	assign shift_ready = fifo_wr_ready;

	// ----------------------------------------------------------------
	// system domain: storage latch and output buffer
	// ----------------------------------------------------------------
	sys_t sys;
	sys_t next_sys;
	logic latch_rise;
	logic pop;

	assign latch_rise = sys.latch_q2 && !sys.latch_q3;
	assign pop        = fifo_rd_valid;

	always_comb
	begin
		next_sys = sys;
		if (sys_ce)
		begin
			// pin synchronisers; the first stage feeds only the second
			next_sys.latch_q1 = latch_clk;
			next_sys.latch_q2 = sys.latch_q1;
			next_sys.latch_q3 = sys.latch_q2;
			next_sys.oe_n_q1  = output_enable_n;
			next_sys.oe_n_q2  = sys.oe_n_q1;

			// storage copy of the shift chain, rebuilt bit by bit
			if (pop)
				next_sys.mirror = shift_in(sys.mirror, fifo_rd_data);

			case (sys.state)
				LATCH_IDLE:
				begin
					if (latch_rise)
					begin
						// latch waits until the bits shifted before it have landed
						next_sys.state  = LATCH_DRAIN;
						next_sys.settle = SETTLE_ZERO;
					end
				end
				LATCH_DRAIN:
				begin
					if (!fifo_rd_valid)
					begin
						next_sys.state  = LATCH_SETTLE;
						next_sys.settle = SETTLE_ZERO;
					end
				end
				LATCH_SETTLE:
				begin
					if (fifo_rd_valid)
						next_sys.state = LATCH_DRAIN;
					else if (sys.settle == SETTLE_LAST)
					begin
						// all stages move in one step
						next_sys.storage = sys.mirror;
						next_sys.state   = LATCH_IDLE;
					end
					else
						next_sys.settle = sys.settle + SETTLE_ONE;
				end
				default:
				begin
					next_sys.state = LATCH_IDLE;
				end
			endcase

			// clear is held in reset, so storage only passes while it is high
			next_sys.buffer = gate_out(sys.storage, sys.oe_n_q2);
		end
	end

	always_ff @(posedge clk or negedge clr_rst_n)
	begin
		if (!clr_rst_n)
		begin
			sys <= '{
				latch_q1: BIT_CLEAR,
				latch_q2: BIT_CLEAR,
				latch_q3: BIT_CLEAR,
				oe_n_q1:  BIT_SET,
				oe_n_q2:  BIT_SET,
				mirror:   CHANNELS_CLEAR,
				storage:  CHANNELS_CLEAR,
				buffer:   CHANNELS_CLEAR,
				state:    LATCH_IDLE,
				settle:   SETTLE_ZERO
			};
		end
		else
			sys <= next_sys;
	end

	// ----------------------------------------------------------------
	// sink channels
	// ----------------------------------------------------------------
	// open drain: pull low while enabled, never drive high
	genvar ch;
	generate
		for (ch = 0; ch < WIDTH; ch++)
		begin : g_sink
			assign sink_channel_out[ch]  = BIT_CLEAR;
			assign sink_channel_oe_n[ch] = ~sys.buffer[ch];
		end
	endgenerate

	assign sink_channel_on = sys.buffer;
	assign latch_busy      = (sys.state != LATCH_IDLE);
	assign storage_view    = sys.storage;

endmodule

// ---- verification/sink_driver_asserts.sv ----
// port checks for the sink driver
`timescale 1ns/1ns
module sink_driver_asserts
	import sink_driver_pkg::*;
#(
	parameter int unsigned WIDTH = CHANNELS
)
(
	input wire logic             clk,
	input wire logic             arst_n,
	input wire logic             en,
	input wire logic             shift_clk,
	input wire logic             serial_in,
	input wire logic             latch_clk,
	input wire logic             clear_all_n,
	input wire logic             output_enable_n,
	input wire logic             shift_ready,
	input wire logic             bit_lost,
	input wire logic             cascade_serial_out,
	input wire logic [WIDTH-1:0] sink_channel_out,
	input wire logic [WIDTH-1:0] sink_channel_oe_n,
	input wire logic [WIDTH-1:0] sink_channel_on,
	input wire logic             latch_busy,
	input wire logic [WIDTH-1:0] storage_view
);
	wire        rst_n = arst_n & clear_all_n;
	logic [3:0] nsh;
	logic       cas_rise;
	// delayed copy is only judged once the chain is full
	always_ff @(posedge shift_clk or negedge rst_n)
		if (!rst_n)
		begin
			nsh      <= 4'h0;
			cas_rise <= 1'h0;
		end
		else
		begin
			nsh      <= (nsh == 4'hC) ? nsh : nsh + 4'h1;
			cas_rise <= cascade_serial_out;
		end
	property p_cas;
		@(posedge shift_clk) disable iff (!rst_n)
		nsh == 4'hC |-> cascade_serial_out == $past(serial_in, 12);
	endproperty
	a_cas: assert property (p_cas) else $error("cascade not 12 behind");
	property p_fall;
		@(negedge shift_clk) disable iff (!rst_n) cascade_serial_out == cas_rise;
	endproperty
	a_fall: assert property (p_fall) else $error("cascade moved on rise");
	property p_lost;
		@(posedge shift_clk) disable iff (!rst_n) !shift_ready |=> bit_lost;
	endproperty
	a_lost: assert property (p_lost) else $error("refused bit not flagged");
	property p_clr;
		@(posedge clk) disable iff (!arst_n)
		!clear_all_n |-> storage_view == '0 && sink_channel_on == '0 && !bit_lost;
	endproperty
	a_clr: assert property (p_clr) else $error("clear left state");
	property p_off;
		@(posedge clk) disable iff (!rst_n) output_enable_n [*4] |-> sink_channel_on == '0;
	endproperty
	a_off: assert property (p_off) else $error("channel on while disabled");
	property p_follow;
		@(posedge clk) disable iff (!rst_n)
		!output_enable_n [*4] ##0 $stable(storage_view) |-> sink_channel_on == storage_view;
	endproperty
	a_follow: assert property (p_follow) else $error("buffer not storage");
	property p_pins;
		@(posedge clk) disable iff (!rst_n)
		sink_channel_oe_n == ~sink_channel_on && sink_channel_out == '0;
	endproperty
	a_pins: assert property (p_pins) else $error("pin drive wrong");
	property p_busy;
		@(posedge clk) disable iff (!rst_n)
		$rose(latch_busy) |-> latch_busy [*3] ##[1:40] !latch_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("latch length wrong");
	property p_store;
		@(posedge clk) disable iff (!rst_n) !$stable(storage_view) |-> $past(latch_busy);
	endproperty
	a_store: assert property (p_store) else $error("storage moved unlatched");
	c_latch: cover property (@(posedge clk) $fell(latch_busy));
	c_lost: cover property (@(posedge shift_clk) $rose(bit_lost));
	c_on: cover property (@(posedge clk) |sink_channel_on);
endmodule
bind sink_driver sink_driver_asserts #(.WIDTH(WIDTH)) chk (.clk, .arst_n, .en,
	.shift_clk, .serial_in, .latch_clk, .clear_all_n, .output_enable_n, .shift_ready,
	.bit_lost, .cascade_serial_out, .sink_channel_out, .sink_channel_oe_n,
	.sink_channel_on, .latch_busy, .storage_view);

// ---- verification/host_model.sv ----
// host stand-in: gated link clock, serial data, latch pulse
`timescale 1ns/1ns
module host_model
(
	input  wire logic clk,
	input  wire logic shift_ready,
	output logic      shift_clk,
	output logic      serial_in,
	output logic      latch_clk
);
	initial
	begin
		shift_clk = 1'h0;
		serial_in = 1'h0;
		latch_clk = 1'h0;
	end
	// msb first; flood ignores back-pressure on purpose
	task automatic send(input logic [11:0] w, input bit flood);
		for (int i = 11; i >= 0; i--)
		begin
			// ready only refreshes on shift edges: pace bits so the fifo drains
			if (!flood)
				repeat (4) @(negedge clk);
			while (!flood && !shift_ready) #1;
			serial_in = w[i];
			#6 shift_clk = 1'h1;
			#6 shift_clk = 1'h0;
		end
		// released line must not look like valid data
		serial_in = ~w[0];
	endtask
	task automatic latch();
		@(negedge clk) latch_clk <= 1'h1;
		repeat (2) @(negedge clk);
		latch_clk <= 1'h0;
	endtask
endmodule

// ---- verification/sink_driver_tb_top.sv ----
// self-checking bench for the sink driver
`timescale 1ns/1ns
module sink_driver_tb_top;
	logic        clk;
	logic        arst_n;
	logic        en;
	logic        clear_all_n;
	logic        output_enable_n;
	wire         shift_clk, serial_in, latch_clk, shift_ready, bit_lost;
	wire         cascade_serial_out, latch_busy;
	wire  [11:0] sink_channel_out, sink_channel_oe_n, sink_channel_on, storage_view;
	int          err_count;
	int          total_checks;
	int          cycles;
	logic [11:0] w;
	logic [11:0] exp_q[$];

	sink_driver uut (.clk, .arst_n, .en, .shift_clk, .serial_in, .latch_clk, .clear_all_n,
		.output_enable_n, .shift_ready, .bit_lost, .cascade_serial_out, .sink_channel_out,
		.sink_channel_oe_n, .sink_channel_on, .latch_busy, .storage_view);
	host_model host (.clk, .shift_ready, .shift_clk, .serial_in, .latch_clk);

	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// busy shows only after the latch edge crosses over
	task automatic snap(input logic [11:0] v);
		exp_q.push_back(v);
		host.latch();
		repeat (4) @(negedge clk);
		for (int i = 0; i < 60 && latch_busy; i++)
			@(negedge clk);
	endtask
	always @(negedge latch_busy)
	begin
		#1;
		if (exp_q.size() > 0)
			chk(storage_view, exp_q.pop_front());
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		arst_n = 1'h0;
		en = 1'h1;
		clear_all_n = 1'h1;
		output_enable_n = 1'h1;
		void'($urandom(32'h6F98));
		repeat (8) @(negedge clk);
		chk(sink_channel_oe_n, 12'hFFF);
		arst_n = 1'h1;
		repeat (2) @(negedge clk);
		#3;
		w = 12'($urandom());
		host.send(w, 0);
		snap(w);
		chk(sink_channel_on, 12'h000);
		output_enable_n = 1'h0;
		repeat (4) @(negedge clk);
		chk(sink_channel_on, w);
		chk(sink_channel_oe_n, ~w);
		host.send(12'hA5C, 0);
		repeat (8) @(negedge clk);
		chk(sink_channel_on, w);
		chk({11'h0, cascade_serial_out}, 12'h001);
		snap(12'hA5C);
		for (int i = 0; i < 5; i++)
		begin
			w = (i == 4) ? 12'hFFF : 12'($urandom());
			host.send(w, 0);
			snap(w);
		end
		repeat (2) @(negedge clk);
		chk(sink_channel_on, w);
		host.send(12'h3C3, 1);
		#20;
		chk({11'h0, bit_lost}, 12'h001);
		@(negedge clk) clear_all_n = 1'h0;
		@(negedge clk);
		chk(storage_view, 12'h000);
		chk(sink_channel_on, 12'h000);
		chk({11'h0, bit_lost}, 12'h000);
		clear_all_n = 1'h1;
		repeat (2) @(negedge clk);
		tally_and_finish();
	end
endmodule
